// ==== bench/mem_model.sv ====
`timescale 1ns/1ps
module mem_model
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic oe_pin_n,
    input wire logic rw_pin,
    input wire logic [23:1] addr_pin,
    input wire logic [3:0] ack_after,
    output logic [15:0] data_pin_in,
    output logic transfer_ack_n
);
    logic [15:0] last_r;
    logic [3:0] cnt_r;
    logic active;

    assign active = !oe_pin_n || !rw_pin;
    // released lines show the inverse of the last level, so stale reads fail
    assign data_pin_in = !oe_pin_n ? {addr_pin[8:1], ~addr_pin[8:1]}
        : ~last_r;
    // ack_after of zero never acknowledges: the port must end on its own
    assign transfer_ack_n = !(active && ack_after != 4'h0
        && cnt_r >= ack_after);

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            last_r <= 16'h0000;
            cnt_r <= 4'h0;
        end
        else
        begin
            last_r <= data_pin_in;
            cnt_r <= active ? cnt_r + 4'h1 : 4'h0;
        end
    end
endmodule : mem_model

// ==== bench/tb_ext_bus_port.sv ====
`timescale 1ns/1ps
module tb_ext_bus_port;
    logic clk, rst_n, req_valid, req_ready, req_write, req_byte;
    logic [24:0] req_addr;
    logic [15:0] req_wdata, resp_rdata, data_pin_in, data_pin_out;
    logic resp_valid, addr_top_bit, rw_pin, oe_pin_n, ctl_oe_n;
    logic [23:1] addr_pin;
    logic [2:0] cs_pin_n;
    logic data_pin_oe_n, transfer_ack_n, pin_float_ctl, dbg_pin_oe_n;
    logic [3:0] debug_word_in, cpu_state_in, debug_word_pin, cpu_state_pin;
    logic [3:0] ack_after;
    int n_errors = 0;
    int checks = 0;

    ext_bus_port u_dut (.clk(clk), .rst_n(rst_n), .req_valid(req_valid),
        .req_ready(req_ready), .req_write(req_write), .req_byte(req_byte),
        .req_addr(req_addr), .req_wdata(req_wdata), .resp_valid(resp_valid),
        .resp_rdata(resp_rdata), .addr_pin(addr_pin),
        .addr_top_bit(addr_top_bit), .rw_pin(rw_pin), .oe_pin_n(oe_pin_n),
        .cs_pin_n(cs_pin_n), .ctl_oe_n(ctl_oe_n), .data_pin_in(data_pin_in),
        .data_pin_out(data_pin_out), .data_pin_oe_n(data_pin_oe_n),
        .transfer_ack_n(transfer_ack_n), .pin_float_ctl(pin_float_ctl),
        .debug_word_in(debug_word_in), .cpu_state_in(cpu_state_in),
        .debug_word_pin(debug_word_pin), .cpu_state_pin(cpu_state_pin),
        .dbg_pin_oe_n(dbg_pin_oe_n));

    mem_model u_mem (.clk(clk), .rst_n(rst_n), .oe_pin_n(oe_pin_n),
        .rw_pin(rw_pin), .addr_pin(addr_pin), .ack_after(ack_after),
        .data_pin_in(data_pin_in), .transfer_ack_n(transfer_ack_n));

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp,
        input string msg);
        checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("unexpected at %0t: %s seen %h expected %h",
                $time, msg, seen, exp);
        end
    endtask : check

    task automatic results;
        if (n_errors == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : results

    // w < 0 marks a dram access; chk off where the wait is too short for data
    task automatic do_req(input logic wr, input logic by, input logic [24:0] a,
        input logic [15:0] wd, input int w, input logic [2:0] cs_exp,
        input logic [3:0] ack, input logic chk);
        int n;
        logic dram;
        logic [15:0] exp_d;
        dram = (w < 0);
        ack_after = ack;
        repeat (3) @(posedge clk);
        #2;
        req_valid = 1'b1;
        req_write = wr;
        req_byte = by;
        req_addr = a;
        req_wdata = wd;
        check(req_ready, 1'b1, "ready in idle");
        @(posedge clk);
        #2;
        req_valid = 1'b0;
        n = 1;
        while (resp_valid !== 1'b1 && n < 40)
        begin
            check(rw_pin, !wr, "direction");
            check(oe_pin_n, wr, "output enable");
            check(cs_pin_n, cs_exp, "chip select");
            if (dram && n == 1)
                check(addr_pin[15:1], a[24:10], "row");
            else if (dram)
                check(addr_pin[9:1], a[9:1], "column");
            else
                check({addr_top_bit, addr_pin},
                    a[24:1], "addr");
            if (!(dram && n == 1))
            begin
                check(data_pin_oe_n, !wr, "data drive");
                if (wr)
                    check(data_pin_out,
                        by ? {2{wd[7:0]}} : wd, "wdata");
            end
            @(posedge clk);
            #2;
            n++;
        end
        if (dram)
            check(n, ack + 4, "ack end");
        else
            check(n, w + 2, "cycle length");
        check({cs_pin_n, oe_pin_n, data_pin_oe_n}, 5'h1f,
            "released");
        if (!wr && chk)
        begin
            exp_d = by ? {8'h00, a[0] ? ~a[8:1] : a[8:1]} : {a[8:1], ~a[8:1]};
            check(resp_rdata, exp_d, "read data");
        end
    endtask : do_req

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        repeat (3) @(posedge clk);
        check(dbg_pin_oe_n, 1'b1, "debug pins in reset");
        check({req_ready, rw_pin, oe_pin_n, cs_pin_n, data_pin_oe_n},
            7'h7f, "reset pins");
        #2;
        rst_n = 1'b1;
        debug_word_in = 4'ha;
        cpu_state_in = 4'h5;
        repeat (2) @(posedge clk);
        #2;
        check(dbg_pin_oe_n, 1'b0, "debug pins after reset");
        check(ctl_oe_n, 1'b0, "bus pins own function");
        check({debug_word_pin, cpu_state_pin}, 8'ha5,
            "status copy");
    endtask : t_reset

    task automatic t_regions;
        logic [24:0] a;
        for (int i = 0; i < 3; i++)
        begin
            a = ebus_pkg::CS_BASE[i] + 25'h0000146;
            do_req(1'b0, 1'b0, a, 16'h3c5a, int'(ebus_pkg::CS_WAIT[i]),
                ~(3'h1 << i), 4'h0, 1'b0);
            do_req(1'b1, 1'b0, a, 16'h0000, int'(ebus_pkg::CS_WAIT[i]),
                ~(3'h1 << i), 4'h0, i == 2);
        end
    endtask : t_regions

    task automatic t_default;
        int w;
        w = int'(ebus_pkg::DEFAULT_WAIT);
        do_req(1'b1, 1'b0, 25'h060012c, 16'h0000, w, 3'h7,
            4'h0, 1'b1);
        do_req(1'b1, 1'b1, 25'h06000d4, 16'h0000, w, 3'h7,
            4'h0, 1'b1);
        do_req(1'b1, 1'b1, 25'h06000d5, 16'h0000, w, 3'h7,
            4'h0, 1'b1);
        do_req(1'b0, 1'b1, 25'h0600033, 16'h1e87, w, 3'h7,
            4'h0, 1'b0);
    endtask : t_default

    task automatic t_dram;
        do_req(1'b0, 1'b0, 25'h1234566, 16'hc3a5, -1, 3'h7,
            4'h2, 1'b0);
        do_req(1'b1, 1'b0, 25'h1f5a2be, 16'h0000, -1, 3'h7,
            4'h5, 1'b1);
        do_req(1'b1, 1'b1, 25'h1000101, 16'h0000, -1, 3'h7,
            4'h1, 1'b1);
    endtask : t_dram

    task automatic t_float;
        @(posedge clk);
        #2;
        pin_float_ctl = 1'b1;
        repeat (3) @(posedge clk);
        #2;
        check({ctl_oe_n, data_pin_oe_n, dbg_pin_oe_n}, 3'h7,
            "floated");
        pin_float_ctl = 1'b0;
        repeat (3) @(posedge clk);
        #2;
        check({ctl_oe_n, dbg_pin_oe_n}, 2'h0, "driven again");
        do_req(1'b0, 1'b0, 25'h0600010, 16'h8001, 3, 3'h7,
            4'h0, 1'b0);
    endtask : t_float

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // whole run is about 120 cycles; the 5000-cycle limit leaves ample margin
    initial
    begin
        #200000;
        n_errors++;
        results();
    end

    initial
    begin
        rst_n = 1'b0;
        req_valid = 1'b0;
        req_write = 1'b0;
        req_byte = 1'b0;
        req_addr = 25'h0000000;
        req_wdata = 16'h0000;
        pin_float_ctl = 1'b0;
        debug_word_in = 4'h0;
        cpu_state_in = 4'h0;
        ack_after = 4'h0;
        t_reset();
        t_regions();
        t_default();
        t_dram();
        t_float();
        results();
    end
endmodule : tb_ext_bus_port

// ==== verilog/cs_decode_if.sv ====
`timescale 1ns/1ps
interface cs_decode_if;
    logic [ebus_pkg::ADDR_W-1:0] addr;
    logic [ebus_pkg::NUM_CS-1:0] cs_hit;
    logic dram_hit;
    logic [ebus_pkg::WAIT_W-1:0] wait_cnt;

    modport decoder (input addr, output cs_hit, output dram_hit,
                     output wait_cnt);
    modport port (output addr, input cs_hit, input dram_hit,
                  input wait_cnt);
endinterface : cs_decode_if

// ==== verilog/ebus_pkg.sv ====
package ebus_pkg;

    localparam int ADDR_W = 25;
    localparam int DATA_W = 16;
    localparam int NUM_CS = 3;
    localparam int COL_BITS = 9;
    localparam int WAIT_W = 4;

    // cycles used when an address hits no region (default bus setup)
    localparam logic [WAIT_W-1:0] DEFAULT_WAIT = 4'h3;

    // chip select regions: an address hits when (addr & mask) == base
    localparam logic [NUM_CS-1:0][ADDR_W-1:0] CS_BASE =
        {25'h0400000, 25'h0200000, 25'h0000000};
    localparam logic [NUM_CS-1:0][ADDR_W-1:0] CS_MASK =
        {25'h1e00000, 25'h1e00000, 25'h1e00000};
    localparam logic [NUM_CS-1:0][WAIT_W-1:0] CS_WAIT =
        {4'h2, 4'h1, 4'h1};

    localparam logic [ADDR_W-1:0] DRAM_BASE = 25'h1000000;
    localparam logic [ADDR_W-1:0] DRAM_MASK = 25'h1000000;

    localparam logic RW_READ = 1'b1;
    localparam logic RW_WRITE = 1'b0;

    localparam logic ACK_IDLE = 1'b1;
    localparam logic [3:0] PIN_IDLE = 4'h0;
    localparam logic [DATA_W-1:0] DATA_RESET = 16'h0000;

    typedef enum logic [3:0]
    {
        ST_IDLE = 4'b0001,
        ST_ROW = 4'b0010,
        ST_XFER = 4'b0100,
        ST_DONE = 4'b1000
    } bus_state_t;

endpackage : ebus_pkg

// ==== verilog/ext_bus_port.sv ====
// Notes on behaviour
// - The address pins carry address bits 24 to 1, one value for both bytes of a word; bit 0 only picks the lane of a byte read.
// - On a dram access the address pins show the row first and then the column.
// - Address bits 23 to 1 come out on the bus and bit 24 on its own top pin, with no bit 0.
// - The direction pin is low during a write cycle and high during a read cycle.
// - The output enable is driven low during read cycles.
// - Data moves over sixteen non-multiplexed two-way lines.
// - Read data is taken from the data lines on a rising clock edge.
// - An address that hits no region and no dram bank runs with the default bus setup.
// - Every write drives all sixteen data lines whatever the size or port width.
// - While the float control input is high the output pins are released.
// - From power-on reset every bus pin serves its bus function.
// - The debug word and processor state pins stay released while reset is applied.
// - Active-low chip selects let asynchronous memories attach without glue.
`timescale 1ns/1ps
module ext_bus_port
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic req_valid,
    output logic req_ready,
    input wire logic req_write,
    input wire logic req_byte,
    input wire logic [ebus_pkg::ADDR_W-1:0] req_addr,
    input wire logic [ebus_pkg::DATA_W-1:0] req_wdata,
    output logic resp_valid,
    output logic [ebus_pkg::DATA_W-1:0] resp_rdata,
    output logic [23:1] addr_pin,
    output logic addr_top_bit,
    output logic rw_pin,
    output logic oe_pin_n,
    output logic [ebus_pkg::NUM_CS-1:0] cs_pin_n,
    output logic ctl_oe_n,
    input wire logic [ebus_pkg::DATA_W-1:0] data_pin_in,
    output logic [ebus_pkg::DATA_W-1:0] data_pin_out,
    output logic data_pin_oe_n,
    input wire logic transfer_ack_n,
    input wire logic pin_float_ctl,
    input wire logic [3:0] debug_word_in,
    input wire logic [3:0] cpu_state_in,
    output logic [3:0] debug_word_pin,
    output logic [3:0] cpu_state_pin,
    output logic dbg_pin_oe_n
);

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers: data and acknowledge share latency, so they align
    logic ack_s1_r, ack_s2_r, float_s1_r, float_s2_r;
    logic [ebus_pkg::DATA_W-1:0] data_s1_r, data_s2_r;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ack_s1_r <= ebus_pkg::ACK_IDLE;
            ack_s2_r <= ebus_pkg::ACK_IDLE;
            float_s1_r <= 1'b0;
            float_s2_r <= 1'b0;
            data_s1_r <= ebus_pkg::DATA_RESET;
            data_s2_r <= ebus_pkg::DATA_RESET;
        end
        else
        begin
            ack_s1_r <= transfer_ack_n;
            ack_s2_r <= ack_s1_r;
            float_s1_r <= pin_float_ctl;
            float_s2_r <= float_s1_r;
            data_s1_r <= data_pin_in;
            data_s2_r <= data_s1_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // region decode
    cs_decode_if dif ();
    assign dif.addr = req_addr;

    region_decode u_decode (.dif(dif));

    ////////////////////////////////////////////////////////////////////////
    // bus cycle sequencer
    ebus_pkg::bus_state_t state_r, state_nxt;
    logic [ebus_pkg::ADDR_W-1:0] addr_r, addr_nxt;
    logic [24:1] abus_r, abus_nxt, row_w, col_w;
    logic write_r, write_nxt, byte_r, byte_nxt, dram_r, dram_nxt, done;
    logic [ebus_pkg::NUM_CS-1:0] cs_r, cs_nxt;
    logic [ebus_pkg::WAIT_W-1:0] wait_r, wait_nxt;
    logic [ebus_pkg::DATA_W-1:0] wdata_r, wdata_nxt, rdata_r, rdata_nxt;

    assign row_w = {{ebus_pkg::COL_BITS{1'b0}},
                    addr_r[24:ebus_pkg::COL_BITS+1]};
    assign col_w = {{(24-ebus_pkg::COL_BITS){1'b0}},
                    addr_r[ebus_pkg::COL_BITS:1]};
    // dram cycles need the controller's acknowledge; others also self-end
    assign done = !ack_s2_r || (wait_r == '0 && !dram_r);

    always_comb
    begin
        state_nxt = state_r;
        addr_nxt = addr_r;
        abus_nxt = abus_r;
        write_nxt = write_r;
        byte_nxt = byte_r;
        dram_nxt = dram_r;
        cs_nxt = cs_r;
        wait_nxt = wait_r;
        wdata_nxt = wdata_r;
        rdata_nxt = rdata_r;
        case (state_r)
            ebus_pkg::ST_IDLE:
            begin
                if (req_valid)
                begin
                    addr_nxt = req_addr;
                    write_nxt = req_write;
                    byte_nxt = req_byte;
                    dram_nxt = dif.dram_hit;
                    cs_nxt = dif.cs_hit;
                    wait_nxt = dif.wait_cnt;
                    // a byte is copied to both lanes so all lines drive
                    wdata_nxt = req_byte ? {2{req_wdata[7:0]}}
                                         : req_wdata;
                    if (dif.dram_hit)
                    begin
                        abus_nxt = {{ebus_pkg::COL_BITS{1'b0}},
                            req_addr[24:ebus_pkg::COL_BITS+1]};
                        state_nxt = ebus_pkg::ST_ROW;
                    end
                    else
                    begin
                        abus_nxt = req_addr[24:1];
                        state_nxt = ebus_pkg::ST_XFER;
                    end
                end
            end
            ebus_pkg::ST_ROW:
            begin
                abus_nxt = col_w;
                state_nxt = ebus_pkg::ST_XFER;
            end
            ebus_pkg::ST_XFER:
            begin
                wait_nxt = (wait_r != '0) ? wait_r - 1'b1 : wait_r;
                if (done)
                begin
                    // even byte sits on the upper lane
                    if (!write_r)
                    begin
                        rdata_nxt = !byte_r ? data_s2_r : {8'h00,
                            addr_r[0] ? data_s2_r[7:0] : data_s2_r[15:8]};
                    end
                    state_nxt = ebus_pkg::ST_DONE;
                end
            end
            ebus_pkg::ST_DONE:
            begin
                cs_nxt = '0;
                state_nxt = ebus_pkg::ST_IDLE;
            end
            default:
            begin
                state_nxt = ebus_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_r <= ebus_pkg::ST_IDLE;
            addr_r <= '0;
            abus_r <= '0;
            write_r <= 1'b0;
            byte_r <= 1'b0;
            dram_r <= 1'b0;
            cs_r <= '0;
            wait_r <= '0;
            wdata_r <= ebus_pkg::DATA_RESET;
            rdata_r <= ebus_pkg::DATA_RESET;
        end
        else
        begin
            state_r <= state_nxt;
            addr_r <= addr_nxt;
            abus_r <= abus_nxt;
            write_r <= write_nxt;
            byte_r <= byte_nxt;
            dram_r <= dram_nxt;
            cs_r <= cs_nxt;
            wait_r <= wait_nxt;
            wdata_r <= wdata_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // debug and status pins: released in reset, driven once it ends
    logic dbg_en_r, dbg_en_nxt;
    logic [3:0] dbg_word_r, dbg_word_nxt, cpu_st_r, cpu_st_nxt;

    always_comb
    begin
        dbg_en_nxt = 1'b1;
        dbg_word_nxt = debug_word_in;
        cpu_st_nxt = cpu_state_in;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            dbg_en_r <= 1'b0;
            dbg_word_r <= ebus_pkg::PIN_IDLE;
            cpu_st_r <= ebus_pkg::PIN_IDLE;
        end
        else
        begin
            dbg_en_r <= dbg_en_nxt;
            dbg_word_r <= dbg_word_nxt;
            cpu_st_r <= cpu_st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pin drive
    logic bus_active, writing;

    assign bus_active = state_r == ebus_pkg::ST_ROW ||
                        state_r == ebus_pkg::ST_XFER;
    assign writing = state_r == ebus_pkg::ST_XFER && write_r;

    assign req_ready = state_r == ebus_pkg::ST_IDLE;
    assign resp_valid = state_r == ebus_pkg::ST_DONE;
    assign resp_rdata = rdata_r;
    assign addr_pin = abus_r[23:1];
    assign addr_top_bit = abus_r[24];
    assign rw_pin = (bus_active && write_r) ? ebus_pkg::RW_WRITE
                                            : ebus_pkg::RW_READ;
    assign oe_pin_n = !(bus_active && !write_r);
    assign cs_pin_n = bus_active ? ~cs_r : '1;
    // no pin multiplexing here: bus function owns the pins from reset on
    assign ctl_oe_n = float_s2_r;
    assign data_pin_out = wdata_r;
    assign data_pin_oe_n = !writing || float_s2_r;
    assign debug_word_pin = dbg_word_r;
    assign cpu_state_pin = cpu_st_r;
    assign dbg_pin_oe_n = !dbg_en_r || float_s2_r;

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    logic in_xfer, rd_xfer;
    assign in_xfer = state_r == ebus_pkg::ST_XFER;
    assign rd_xfer = in_xfer && !write_r;

    rw_write_low_a: assert property (writing |-> !rw_pin)
        else $error("direction pin not low in write");
    rw_read_high_a: assert property (rd_xfer |-> rw_pin)
        else $error("direction pin not high in read");
    oe_read_low_a: assert property (rd_xfer |-> !oe_pin_n)
        else $error("output enable not low in read");
    write_drive_a: assert property (writing && !float_s2_r |->
        !data_pin_oe_n && (!byte_r || data_pin_out[15:8] == data_pin_out[7:0]))
        else $error("data lines not all driven in write");
    data_release_a: assert property (!writing |-> data_pin_oe_n)
        else $error("data lines driven outside write");
    float_pins_a: assert property (float_s2_r |->
        ctl_oe_n && data_pin_oe_n && dbg_pin_oe_n)
        else $error("pins driven while floated");
    ack_ends_a: assert property (in_xfer && !ack_s2_r |=>
        resp_valid ##1 req_ready)
        else $error("acknowledge did not end cycle");
    read_capture_a: assert property (rd_xfer && !byte_r
        && !ack_s2_r |=> resp_rdata == $past(data_s2_r))
        else $error("read data not captured");
    row_then_col_a: assert property (state_r == ebus_pkg::ST_ROW
        && abus_r == row_w |=> in_xfer && abus_r == $past(col_w))
        else $error("column did not follow row");
    plain_addr_a: assert property (in_xfer && !dram_r |->
        abus_r == addr_r[24:1])
        else $error("address pins wrong");
    default_end_a: assert property (in_xfer && !dram_r
        && cs_r == '0 && wait_r == ebus_pkg::DEFAULT_WAIT
        |-> ##[1:4] resp_valid)
        else $error("default cycle did not end");
    cs_select_a: assert property (in_xfer && !dram_r
        && (addr_r & ebus_pkg::CS_MASK[0]) == ebus_pkg::CS_BASE[0]
        |-> cs_pin_n == 3'b110)
        else $error("chip select not asserted");

    write_seen_c: cover property (writing ##[1:8] resp_valid);
    read_seen_c: cover property (in_xfer && !write_r && !ack_s2_r);
    dram_seen_c: cover property (state_r == ebus_pkg::ST_ROW ##1 in_xfer);
    default_seen_c: cover property (in_xfer && cs_r == '0 && !dram_r);

endmodule : ext_bus_port

// ==== verilog/region_decode.sv ====
`timescale 1ns/1ps
module region_decode
(
    cs_decode_if.decoder dif
);

    logic [ebus_pkg::NUM_CS-1:0] raw_hit;

    genvar g;
    generate
        for (g = 0; g < ebus_pkg::NUM_CS; g = g + 1)
        begin : g_region
            assign raw_hit[g] = (dif.addr & ebus_pkg::CS_MASK[g]) ==
                                ebus_pkg::CS_BASE[g];
        end
    endgenerate

    // lowest region wins; dram bank outranks every chip select
    always_comb
    begin
        dif.cs_hit = '0;
        dif.wait_cnt = ebus_pkg::DEFAULT_WAIT;
        dif.dram_hit = (dif.addr & ebus_pkg::DRAM_MASK) ==
                       ebus_pkg::DRAM_BASE;
        if (!dif.dram_hit)
        begin
            for (int i = ebus_pkg::NUM_CS - 1; i >= 0; i--)
            begin
                if (raw_hit[i])
                begin
                    dif.cs_hit = '0;
                    dif.cs_hit[i] = 1'b1;
                    dif.wait_cnt = ebus_pkg::CS_WAIT[i];
                end
            end
        end
    end

endmodule : region_decode
